/* File: rtl/ciex_consts.svh */
// Constants for the control instruction exception unit
// Operation
// - Software exception entry copies status into saved status and records return address.
// - Software exception entry then redirects fetch to the general exception handler.
// - Exception return restores status from saved status and resumes at return address.
// - Debug break entry and debug return exist, for debugging tools only.
// - Control register read moves to general register; write stores from general register.
// - Four cache operations: data flush, instruction flush, data and instruction invalidate.
// - Prefetch discard drops all prefetched instructions from the pipeline.
// - Memory barrier stalls later loads and stores until earlier operations complete.
// - Custom instruction passes operands to and takes results from user logic.
// - Presence of the custom instruction path is a build-time parameter.
// - Missing multiply or divide hardware for an instruction raises the unimplemented instruction exception.
// - Only multiply and divide variants may raise the unimplemented instruction exception.
// - No other instruction ever raises the unimplemented instruction exception.
// - No-operation changes no register, memory or processor state, except that cache_addr_o loads gpr_a_i as on any accepted issue.
`ifndef CIEX_CONSTS_SVH
`define CIEX_CONSTS_SVH
`define CIEX_XLEN 32
`define CIEX_STATUS_W 32
`define CIEX_STATUS_RST 32'h0000_0000
`define CIEX_STATUS_PIE_BIT 0
`define CIEX_EXC_VECTOR 32'h0000_0020
`define CIEX_BRK_VECTOR 32'h0000_0040
`define CIEX_CTL_STATUS 3'h0
`define CIEX_CTL_SAVED 3'h1
`define CIEX_CTL_BSTATUS 3'h2
`define CIEX_CTL_EPC 3'h3
`define CIEX_CTL_BPC 3'h4
`endif

/* File: rtl/ciex_pkg.sv */
// Types for the control instruction exception unit
package ciex_pkg;
   typedef enum logic [4:0] {
      CIEX_OP_NOP = 5'h00,
      CIEX_OP_TRAP = 5'h01,
      CIEX_OP_ERET = 5'h02,
      CIEX_OP_BREAK = 5'h03,
      CIEX_OP_BRET = 5'h04,
      CIEX_OP_RDCTL = 5'h05,
      CIEX_OP_WRCTL = 5'h06,
      CIEX_OP_FLUSHD = 5'h07,
      CIEX_OP_FLUSHI = 5'h08,
      CIEX_OP_INITD = 5'h09,
      CIEX_OP_INITI = 5'h0a,
      CIEX_OP_FLUSHP = 5'h0b,
      CIEX_OP_SYNC = 5'h0c,
      CIEX_OP_CUSTOM = 5'h0d,
      CIEX_OP_MUL = 5'h10,
      CIEX_OP_MULI = 5'h11,
      CIEX_OP_MULXSS = 5'h12,
      CIEX_OP_MULXSU = 5'h13,
      CIEX_OP_MULXUU = 5'h14,
      CIEX_OP_DIV = 5'h15,
      CIEX_OP_DIVU = 5'h16,
      CIEX_OP_OTHER = 5'h1f
   } ciex_op_t;
   typedef enum logic [1:0] {
      CIEX_ST_IDLE = 2'b00,
      CIEX_ST_SYNC = 2'b01,
      CIEX_ST_CUST = 2'b11
   } ciex_state_t;
endpackage

/* File: rtl/ciex_unimp_chk.sv */
// Unimplemented multiply and divide detector
`timescale 1ns/100ps
module ciex_unimp_chk #(
   parameter bit HAS_MUL = 1'b0,
   parameter bit HAS_MULX = 1'b0,
   parameter bit HAS_DIV = 1'b0
) (
   input wire ciex_pkg::ciex_op_t op_i,
   output wire unimp_o
);
   // Class decode of the instruction
   wire is_mul = (op_i == ciex_pkg::CIEX_OP_MUL) || (op_i == ciex_pkg::CIEX_OP_MULI);
   wire is_mulx = (op_i == ciex_pkg::CIEX_OP_MULXSS) || (op_i == ciex_pkg::CIEX_OP_MULXSU) ||
                  (op_i == ciex_pkg::CIEX_OP_MULXUU);
   wire is_div = (op_i == ciex_pkg::CIEX_OP_DIV) || (op_i == ciex_pkg::CIEX_OP_DIVU);
   // Only these classes can trip, and only when hardware is absent
   assign unimp_o = (is_mul && !HAS_MUL) || (is_mulx && !HAS_MULX) || (is_div && !HAS_DIV);
endmodule

/* File: rtl/ciex_unit.sv */
// Control instruction execution and exception unit
`timescale 1ns/100ps
`include "ciex_consts.svh"
module ciex_unit #(
   parameter bit HAS_CUSTOM = 1'b1,
   parameter bit HAS_MUL = 1'b0,
   parameter bit HAS_MULX = 1'b0,
   parameter bit HAS_DIV = 1'b0
) (
   input wire clk_i,
   input wire srst_i,
   input wire issue_i,
   input wire ciex_pkg::ciex_op_t op_i,
   input wire [31:0] pc_i,
   input wire [2:0] ctl_sel_i,
   input wire [31:0] gpr_a_i,
   input wire [31:0] gpr_b_i,
   input wire [4:0] gpr_dst_i,
   input wire mem_idle_i,
   input wire cust_done_i,
   input wire [31:0] cust_result_i,
   output wire busy_o,
   output wire ldst_stall_o,
   output logic redirect_o,
   output logic [31:0] redirect_pc_o,
   output logic prefetch_flush_o,
   output logic gpr_we_o,
   output logic [4:0] gpr_waddr_o,
   output logic [31:0] gpr_wdata_o,
   output logic dcache_flush_o,
   output logic icache_flush_o,
   output logic dcache_inval_o,
   output logic icache_inval_o,
   output logic [31:0] cache_addr_o,
   output logic cust_start_o,
   output logic [31:0] cust_a_o,
   output logic [31:0] cust_b_o,
   output logic unimp_exc_o,
   output logic debug_mode_o,
   output logic [31:0] status_o
);
   ciex_pkg::ciex_state_t state_r, state_nxt;
   logic [31:0] status_r, saved_status_r, brk_status_r;
   logic [31:0] exception_return_address_r, brk_return_r;
   logic [4:0] cust_dst_r;
   wire unimp;
   wire [31:0] ret_addr = pc_i + 32'h0000_0004;

   // Unimplemented instruction detection
   ciex_unimp_chk #(
      .HAS_MUL(HAS_MUL),
      .HAS_MULX(HAS_MULX),
      .HAS_DIV(HAS_DIV)
   ) u_unimp (
      .op_i(op_i),
      .unimp_o(unimp)
   );

   // Issue decode
   wire take = issue_i && (state_r == ciex_pkg::CIEX_ST_IDLE);
   wire do_unimp = take && unimp;
   wire do_trap = take && (op_i == ciex_pkg::CIEX_OP_TRAP);
   wire do_enter = do_trap || do_unimp;
   wire do_eret = take && (op_i == ciex_pkg::CIEX_OP_ERET);
   wire do_break = take && (op_i == ciex_pkg::CIEX_OP_BREAK);
   wire do_bret = take && (op_i == ciex_pkg::CIEX_OP_BRET);
   wire do_rdctl = take && (op_i == ciex_pkg::CIEX_OP_RDCTL);
   wire do_wrctl = take && (op_i == ciex_pkg::CIEX_OP_WRCTL);
   wire do_flushp = take && (op_i == ciex_pkg::CIEX_OP_FLUSHP);
   wire do_sync = take && (op_i == ciex_pkg::CIEX_OP_SYNC);
   wire do_cust = take && (op_i == ciex_pkg::CIEX_OP_CUSTOM) && HAS_CUSTOM;
   wire cust_fin = (state_r == ciex_pkg::CIEX_ST_CUST) && cust_done_i;

   // Control register selection for reads
   wire [31:0] ctl_rdata =
      (ctl_sel_i == `CIEX_CTL_STATUS) ? status_r :
      (ctl_sel_i == `CIEX_CTL_SAVED) ? saved_status_r :
      (ctl_sel_i == `CIEX_CTL_BSTATUS) ? brk_status_r :
      (ctl_sel_i == `CIEX_CTL_EPC) ? exception_return_address_r :
      (ctl_sel_i == `CIEX_CTL_BPC) ? brk_return_r : 32'h0000_0000;

   // Handshakes: stall issue and later memory traffic while waiting
   assign busy_o = (state_r != ciex_pkg::CIEX_ST_IDLE);
   assign ldst_stall_o = do_sync || (state_r == ciex_pkg::CIEX_ST_SYNC);

   // Sequencer for barrier and custom operations
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ciex_pkg::CIEX_ST_IDLE: begin
            if (do_sync && !mem_idle_i) begin
               state_nxt = ciex_pkg::CIEX_ST_SYNC;
            end else if (do_cust) begin
               state_nxt = ciex_pkg::CIEX_ST_CUST;
            end
         end
         ciex_pkg::CIEX_ST_SYNC: begin
            if (mem_idle_i) begin
               state_nxt = ciex_pkg::CIEX_ST_IDLE;
            end
         end
         ciex_pkg::CIEX_ST_CUST: begin
            if (cust_done_i) begin
               state_nxt = ciex_pkg::CIEX_ST_IDLE;
            end
         end
         default: begin
            state_nxt = ciex_pkg::CIEX_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_r <= ciex_pkg::CIEX_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Processor state, saved state and return addresses
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         status_r <= `CIEX_STATUS_RST;
         saved_status_r <= `CIEX_STATUS_RST;
         brk_status_r <= `CIEX_STATUS_RST;
         exception_return_address_r <= 32'h0000_0000;
         brk_return_r <= 32'h0000_0000;
         debug_mode_o <= 1'b0;
      end else if (do_enter) begin
         saved_status_r <= status_r;
         exception_return_address_r <= ret_addr;
         status_r[`CIEX_STATUS_PIE_BIT] <= 1'b0;
      end else if (do_eret) begin
         status_r <= saved_status_r;
      end else if (do_break) begin
         brk_status_r <= status_r;
         brk_return_r <= ret_addr;
         status_r[`CIEX_STATUS_PIE_BIT] <= 1'b0;
         debug_mode_o <= 1'b1;
      end else if (do_bret) begin
         status_r <= brk_status_r;
         debug_mode_o <= 1'b0;
      end else if (do_wrctl) begin
         if (ctl_sel_i == `CIEX_CTL_STATUS) begin
            status_r <= gpr_a_i;
         end else if (ctl_sel_i == `CIEX_CTL_SAVED) begin
            saved_status_r <= gpr_a_i;
         end else if (ctl_sel_i == `CIEX_CTL_BSTATUS) begin
            brk_status_r <= gpr_a_i;
         end else if (ctl_sel_i == `CIEX_CTL_EPC) begin
            exception_return_address_r <= gpr_a_i;
         end else if (ctl_sel_i == `CIEX_CTL_BPC) begin
            brk_return_r <= gpr_a_i;
         end
      end
   end

   // Fetch redirection and pipeline flush
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         redirect_o <= 1'b0;
         redirect_pc_o <= 32'h0000_0000;
         prefetch_flush_o <= 1'b0;
         unimp_exc_o <= 1'b0;
      end else begin
         redirect_o <= do_enter || do_eret || do_break || do_bret || do_flushp;
         prefetch_flush_o <= do_enter || do_eret || do_break || do_bret || do_flushp;
         unimp_exc_o <= do_unimp;
         if (do_enter) begin
            redirect_pc_o <= `CIEX_EXC_VECTOR;
         end else if (do_eret) begin
            redirect_pc_o <= exception_return_address_r;
         end else if (do_break) begin
            redirect_pc_o <= `CIEX_BRK_VECTOR;
         end else if (do_bret) begin
            redirect_pc_o <= brk_return_r;
         end else if (do_flushp) begin
            redirect_pc_o <= ret_addr;
         end
      end
   end

   // Cache maintenance strobes
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         dcache_flush_o <= 1'b0;
         icache_flush_o <= 1'b0;
         dcache_inval_o <= 1'b0;
         icache_inval_o <= 1'b0;
         cache_addr_o <= 32'h0000_0000;
      end else begin
         dcache_flush_o <= take && (op_i == ciex_pkg::CIEX_OP_FLUSHD);
         icache_flush_o <= take && (op_i == ciex_pkg::CIEX_OP_FLUSHI);
         dcache_inval_o <= take && (op_i == ciex_pkg::CIEX_OP_INITD);
         icache_inval_o <= take && (op_i == ciex_pkg::CIEX_OP_INITI);
         if (take) begin
            cache_addr_o <= gpr_a_i;
         end
      end
   end

   // Custom logic operand launch
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cust_start_o <= 1'b0;
         cust_a_o <= 32'h0000_0000;
         cust_b_o <= 32'h0000_0000;
         cust_dst_r <= 5'h00;
      end else begin
         cust_start_o <= do_cust;
         if (do_cust) begin
            cust_a_o <= gpr_a_i;
            cust_b_o <= gpr_b_i;
            cust_dst_r <= gpr_dst_i;
         end
      end
   end

   // General register writeback; nop writes nothing
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         gpr_we_o <= 1'b0;
         gpr_waddr_o <= 5'h00;
         gpr_wdata_o <= 32'h0000_0000;
      end else begin
         gpr_we_o <= do_rdctl || cust_fin;
         if (do_rdctl) begin
            gpr_waddr_o <= gpr_dst_i;
            gpr_wdata_o <= ctl_rdata;
         end else if (cust_fin) begin
            gpr_waddr_o <= cust_dst_r;
            gpr_wdata_o <= cust_result_i;
         end
      end
   end

   assign status_o = status_r;
endmodule

/* File: test/ciex_unit_monitor.sv */
// Assertion checker for the control instruction unit
`timescale 1ns/100ps
module ciex_unit_monitor (
   input wire clk_i,
   input wire srst_i,
   input wire issue_i,
   input wire ciex_pkg::ciex_op_t op_i,
   input wire mem_idle_i,
   input wire cust_done_i,
   input wire busy_o,
   input wire ldst_stall_o,
   input wire redirect_o,
   input wire [31:0] redirect_pc_o,
   input wire prefetch_flush_o,
   input wire gpr_we_o,
   input wire cust_start_o,
   input wire unimp_exc_o,
   input wire debug_mode_o,
   input wire [31:0] status_o
);
   // Accepted issue
   wire take = issue_i && !busy_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // Barrier wait steps
   sequence s_stall;
      ldst_stall_o ##1 (busy_o && ldst_stall_o);
   endsequence
   a_trap_vector: assert property (take && op_i == ciex_pkg::CIEX_OP_TRAP |=>
      redirect_o && prefetch_flush_o && redirect_pc_o == 32'h0000_0020) else $error("trap vector wrong");
   a_mul_unimp: assert property (take && op_i == ciex_pkg::CIEX_OP_MUL |=>
      unimp_exc_o && redirect_o) else $error("mul did not trap");
   a_other_no_unimp: assert property (take && !op_i[4] |=> !unimp_exc_o) else $error("bad unimp");
   a_sync_stall: assert property (take && op_i == ciex_pkg::CIEX_OP_SYNC && !mem_idle_i |-> s_stall)
      else $error("barrier did not stall");
   a_sync_release: assert property (busy_o && ldst_stall_o && mem_idle_i |=> !busy_o)
      else $error("barrier did not release");
   a_cust_start: assert property (take && op_i == ciex_pkg::CIEX_OP_CUSTOM |=> cust_start_o && busy_o)
      else $error("custom not started");
   a_cust_result: assert property (busy_o && !ldst_stall_o && cust_done_i |=> gpr_we_o && !busy_o)
      else $error("custom result lost");
   a_rdctl_write: assert property (take && op_i == ciex_pkg::CIEX_OP_RDCTL |=> gpr_we_o)
      else $error("read no write back");
   a_break_enter: assert property (take && op_i == ciex_pkg::CIEX_OP_BREAK |=>
      debug_mode_o && redirect_pc_o == 32'h0000_0040) else $error("break entry wrong");
   a_nop_quiet: assert property (take && op_i == ciex_pkg::CIEX_OP_NOP |=>
      !redirect_o && !gpr_we_o && $stable(status_o)) else $error("nop changed state");
endmodule
bind ciex_unit ciex_unit_monitor u_mon (.clk_i, .srst_i, .issue_i, .op_i, .mem_idle_i, .cust_done_i, .busy_o,
   .ldst_stall_o, .redirect_o, .redirect_pc_o, .prefetch_flush_o, .gpr_we_o, .cust_start_o, .unimp_exc_o,
   .debug_mode_o, .status_o);

/* File: test/ciex_unit_test.sv */
// Testbench for the control instruction unit
`timescale 1ns/100ps
module ciex_unit_test;
   logic clk_i = 0, srst_i = 1, issue_i = 0, mem_idle_i = 1, cust_done_i = 0;
   ciex_pkg::ciex_op_t op_i = ciex_pkg::CIEX_OP_NOP;
   logic [31:0] pc_i = 0, gpr_a_i = 0, gpr_b_i = 0, cust_result_i = 0;
   logic [2:0] ctl_sel_i = 0;
   logic [4:0] gpr_dst_i = 5'h03;
   wire busy_o, ldst_stall_o, redirect_o, prefetch_flush_o, gpr_we_o, dcache_flush_o, icache_flush_o;
   wire dcache_inval_o, icache_inval_o, cust_start_o, unimp_exc_o, debug_mode_o;
   wire [31:0] redirect_pc_o, gpr_wdata_o, cache_addr_o, cust_a_o, cust_b_o, status_o;
   wire [4:0] gpr_waddr_o;
   int fails = 0, total_checks = 0, i;
   logic [31:0] st;
   ciex_unit uut (.clk_i, .srst_i, .issue_i, .op_i, .pc_i, .ctl_sel_i, .gpr_a_i, .gpr_b_i, .gpr_dst_i,
      .mem_idle_i, .cust_done_i, .cust_result_i, .busy_o, .ldst_stall_o, .redirect_o, .redirect_pc_o,
      .prefetch_flush_o, .gpr_we_o, .gpr_waddr_o, .gpr_wdata_o, .dcache_flush_o, .icache_flush_o,
      .dcache_inval_o, .icache_inval_o, .cache_addr_o, .cust_start_o, .cust_a_o, .cust_b_o, .unimp_exc_o,
      .debug_mode_o, .status_o);
   // Clock
   always #2 clk_i = ~clk_i;
   // Compare one value
   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Final verdict
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One issued instruction, outputs settled on return
   task issue(input ciex_pkg::ciex_op_t op, input logic [31:0] pc, input logic [31:0] a, input logic [2:0] sel);
      @(posedge clk_i);
      #1;
      issue_i = 1;
      op_i = op;
      pc_i = pc;
      gpr_a_i = a;
      gpr_b_i = ~a;
      ctl_sel_i = sel;
      @(posedge clk_i);
      #1;
      issue_i = 0;
   endtask
   // Bounded wait for idle
   task wait_idle;
      for (i = 0; i < 20 && busy_o !== 1'b0; i++) begin
         @(posedge clk_i);
         #1;
      end
      if (i == 20) begin
         fails++;
         $display("mismatch at %0t: busy timeout", $time);
         report_and_stop;
      end
   endtask
   task t_trap;
      issue(ciex_pkg::CIEX_OP_WRCTL, 0, 1, 0);
      check(status_o, 1);
      issue(ciex_pkg::CIEX_OP_TRAP, 32'h0000_0100, 0, 0);
      check({redirect_o, prefetch_flush_o}, 2'b11);
      check(redirect_pc_o, 32'h0000_0020);
      check(status_o, 0);
      issue(ciex_pkg::CIEX_OP_RDCTL, 0, 0, 3);
      check({gpr_we_o, gpr_waddr_o}, 6'h23);
      check(gpr_wdata_o, 32'h0000_0104);
      issue(ciex_pkg::CIEX_OP_RDCTL, 0, 0, 1);
      check(gpr_wdata_o, 1);
      issue(ciex_pkg::CIEX_OP_ERET, 0, 0, 0);
      check(redirect_pc_o, 32'h0000_0104);
      check(status_o, 1);
      $display("trap test done");
   endtask
   task t_break;
      issue(ciex_pkg::CIEX_OP_BREAK, 32'h0000_0200, 0, 0);
      check(debug_mode_o, 1);
      check(redirect_pc_o, 32'h0000_0040);
      check(status_o, 0);
      issue(ciex_pkg::CIEX_OP_BRET, 0, 0, 0);
      check(debug_mode_o, 0);
      check(redirect_pc_o, 32'h0000_0204);
      check(status_o, 1);
      $display("break test done");
   endtask
   task t_cache;
      for (int k = 0; k < 4; k++) begin
         issue(ciex_pkg::ciex_op_t'(5'h07 + k), 0, 32'h0000_1000 + k, 0);
         check({dcache_flush_o, icache_flush_o, dcache_inval_o, icache_inval_o}, 4'b1000 >> k);
         check(cache_addr_o, 32'h0000_1000 + k);
      end
      issue(ciex_pkg::CIEX_OP_FLUSHP, 32'h0000_0300, 0, 0);
      check(prefetch_flush_o, 1);
      check(redirect_pc_o, 32'h0000_0304);
      $display("cache test done");
   endtask
   task t_sync;
      mem_idle_i = 0;
      issue(ciex_pkg::CIEX_OP_SYNC, 0, 0, 0);
      check({busy_o, ldst_stall_o}, 2'b11);
      mem_idle_i = 1;
      wait_idle;
      check(ldst_stall_o, 0);
      $display("sync test done");
   endtask
   task t_custom;
      issue(ciex_pkg::CIEX_OP_CUSTOM, 0, 32'h0000_0055, 0);
      check({cust_start_o, busy_o}, 2'b11);
      check(cust_b_o, 32'hffff_ffaa);
      check(cust_a_o, 32'h0000_0055);
      cust_result_i = 32'h0000_abcd;
      cust_done_i = 1;
      @(posedge clk_i);
      #1;
      cust_done_i = 0;
      check({gpr_we_o, busy_o}, 2'b10);
      check(gpr_wdata_o, 32'h0000_abcd);
      check(gpr_waddr_o, 5'h03);
      $display("custom test done");
   endtask
   task t_unimp;
      for (int k = 0; k < 7; k++) begin
         issue(ciex_pkg::ciex_op_t'(5'h10 + k), 0, 0, 0);
         check(unimp_exc_o, 1);
         check(redirect_pc_o, 32'h0000_0020);
      end
      issue(ciex_pkg::CIEX_OP_RDCTL, 0, 0, 3);
      check(gpr_wdata_o, 32'h0000_0004);
      st = status_o;
      issue(ciex_pkg::CIEX_OP_NOP, 0, 0, 0);
      check({unimp_exc_o, redirect_o, gpr_we_o}, 0);
      check(status_o, st);
      $display("unimp test done");
   endtask
   // Reset in mid-run clears debug state and status
   task t_reset;
      issue(ciex_pkg::CIEX_OP_BREAK, 32'h0000_0500, 0, 0);
      check(debug_mode_o, 1);
      srst_i = 1;
      @(posedge clk_i);
      #1;
      srst_i = 0;
      check({debug_mode_o, busy_o, redirect_o}, 0);
      check(status_o, 32'h0000_0000);
      issue(ciex_pkg::CIEX_OP_TRAP, 32'h0000_0600, 0, 0);
      check(redirect_pc_o, 32'h0000_0020);
      $display("reset test done");
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      #1;
      srst_i = 0;
      t_trap;
      t_break;
      t_cache;
      t_sync;
      t_custom;
      t_unimp;
      t_reset;
      report_and_stop;
   end
endmodule
